// ==== verilog/modulator_out_pkg.sv ====
// Constants, modes and carrier structs for the isolated modulator bitstream output.
// Assumes a single 200 MHz system clock; the sampling clock arrives as a pin level.
package modulator_out_pkg;

    // ************************************************************
    // Clocking and timing
    // ************************************************************
    localparam int SYS_CLK_MHZ = 200;
    localparam int CARRIER_MHZ = 480;
    localparam int CHOP_DIVIDE = 32;
    localparam logic [3:0] CHOP_HALF_LAST = 4'(CHOP_DIVIDE / 2 - 1);
    localparam int MARKER_PERIOD = 128;
    localparam logic [6:0] MARKER_LAST = 7'(MARKER_PERIOD - 1);

    // ************************************************************
    // Input scaling: 1 LSB = 2 uV, clipping level 64 mV
    // ************************************************************
    localparam logic signed [15:0] CLIP_LEVEL = 16'sh7D00;
    localparam logic signed [15:0] NEG_CLIP_LEVEL = 16'sh8300;
    localparam int INT_W = 20;
    localparam int EXT_W = INT_W + 2;
    localparam logic signed [EXT_W-1:0] CLIP_EXT = 22'sh007D00;
    localparam logic signed [EXT_W-1:0] NEG_CLIP_EXT = 22'sh3F8300;
    localparam logic signed [EXT_W-1:0] INT_MAX_EXT = 22'sh07FFFF;
    localparam logic signed [EXT_W-1:0] INT_MIN_EXT = 22'sh380000;

    // ************************************************************
    // Pin synchroniser layout
    // ************************************************************
    localparam int PIN_COUNT = 3;
    localparam int PIN_SUPPLY = 0;
    localparam int PIN_CM = 1;
    localparam int PIN_CLK = 2;

    typedef enum logic [4:0] {
        MODE_LINEAR    = 5'h01,
        MODE_CLIP_POS  = 5'h02,
        MODE_CLIP_NEG  = 5'h04,
        MODE_CM_OVER   = 5'h08,
        MODE_NO_SUPPLY = 5'h10
    } out_mode_e;

    typedef struct packed {
        logic sample_clock_in;
        logic cm_overvoltage;
        logic high_side_supply_ok;
    } pin_in_s;

    typedef struct packed {
        logic bitstream;
        logic carrier_on;
        logic chopper_phase;
        logic bit_strobe;
    } mod_out_s;

endpackage : modulator_out_pkg

// ==== verilog/isolated_modulator_bitstream_out.sv ====
// Digital model of the output side of an isolated second-order delta-sigma modulator.
// Assumes pins arrive asynchronously and the differential input is a same-clock signed code.
//
// Functional notes
// - One output bit is produced per rising edge of the sampling clock and changes only then.
// - The input chopper phase toggles every 16 sample clocks, a full chopper period of 32.
// - The feedback level follows the previous output bit; each bit is the quantizer decision registered on the same sample edge.
// - A zero input ideally gives ones in half of the output bits.
// - At +50 mV the ones density is ideally 89.06 percent, code 58368 after a 16-bit filter.
// - At -50 mV the ones density is ideally 10.94 percent, code 7168 after a 16-bit filter.
// - At or beyond the clipping level the output clips to all zeros or all ones.
// - While clipped, one opposite bit is inserted every 128 sample clocks as a liveness marker.
// - A common-mode overvoltage holds the output high with no marker.
// - A missing high-side supply holds the output low with no marker.
// - A one is sent across the barrier as carrier bursts and a zero as no carrier.
// - Outside clipping the ones density is (input plus clip level) over twice the clip level.
`timescale 1ns/100ps
module isolated_modulator_bitstream_out (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire modulator_out_pkg::pin_in_s i_pins,
    input wire logic signed [15:0] i_diff_input,
    output modulator_out_pkg::mod_out_s o_mod
);
    import modulator_out_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [PIN_COUNT-1:0] pin_vec;
    logic [PIN_COUNT-1:0] pin_filt;

    assign pin_vec = i_pins;

    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_sync
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic filt_ff;
            logic nxt_s1;
            logic nxt_s2;
            logic nxt_s3;
            logic nxt_filt;

            always_comb begin
                nxt_s1 = pin_vec[g];
                nxt_s2 = s1_ff;
                nxt_s3 = s2_ff;
                // Accept a level only once the second and third stages agree
                nxt_filt = (s2_ff == s3_ff) ? s2_ff : filt_ff;
            end

            always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                    filt_ff <= 1'b0;
                end else begin
                    s1_ff <= nxt_s1;
                    s2_ff <= nxt_s2;
                    s3_ff <= nxt_s3;
                    filt_ff <= nxt_filt;
                end
            end

            assign pin_filt[g] = filt_ff;
        end
    endgenerate

    // ************************************************************
    // Sample clock edge
    // ************************************************************
    logic clk_prev_ff;
    logic nxt_clk_prev;
    logic sample_rise;

    always_comb begin
        nxt_clk_prev = pin_filt[PIN_CLK];
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            clk_prev_ff <= 1'b0;
        end else begin
            clk_prev_ff <= nxt_clk_prev;
        end
    end

    assign sample_rise = pin_filt[PIN_CLK] & ~clk_prev_ff;

    // ************************************************************
    // Chopper phase
    // ************************************************************
    logic [3:0] chop_cnt_ff;
    logic [3:0] nxt_chop_cnt;
    logic chop_ff;
    logic nxt_chop;

    always_comb begin
        nxt_chop_cnt = chop_cnt_ff;
        nxt_chop = chop_ff;
        if (sample_rise) begin
            if (chop_cnt_ff == CHOP_HALF_LAST) begin
                nxt_chop_cnt = 4'h0;
                nxt_chop = ~chop_ff;
            end else begin
                nxt_chop_cnt = chop_cnt_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            chop_cnt_ff <= 4'h0;
            chop_ff <= 1'b0;
        end else begin
            chop_cnt_ff <= nxt_chop_cnt;
            chop_ff <= nxt_chop;
        end
    end

    // ************************************************************
    // Modulator core and fault modes
    // ************************************************************
    out_mode_e mode_ff;
    out_mode_e nxt_mode;
    out_mode_e req_mode;
    logic signed [INT_W-1:0] int1_ff;
    logic signed [INT_W-1:0] int2_ff;
    logic signed [INT_W-1:0] nxt_int1;
    logic signed [INT_W-1:0] nxt_int2;
    logic [6:0] clip_cnt_ff;
    logic [6:0] nxt_clip_cnt;
    logic bit_ff;
    logic nxt_bit;
    logic strobe_ff;
    logic nxt_strobe;
    logic signed [EXT_W-1:0] dac_level;
    logic [6:0] cnt_use;
    logic decision;

    function automatic logic signed [INT_W-1:0] sat_int(input logic signed [EXT_W-1:0] v);
        logic signed [EXT_W-1:0] r;
        r = v;
        if (v > INT_MAX_EXT) begin
            r = INT_MAX_EXT;
        end else if (v < INT_MIN_EXT) begin
            r = INT_MIN_EXT;
        end
        return r[INT_W-1:0];
    endfunction : sat_int

    // Supply loss wins over common-mode fault, which wins over clipping
    always_comb begin
        if (!pin_filt[PIN_SUPPLY]) begin
            req_mode = MODE_NO_SUPPLY;
        end else if (pin_filt[PIN_CM]) begin
            req_mode = MODE_CM_OVER;
        end else if (i_diff_input >= CLIP_LEVEL) begin
            req_mode = MODE_CLIP_POS;
        end else if (i_diff_input <= NEG_CLIP_LEVEL) begin
            req_mode = MODE_CLIP_NEG;
        end else begin
            req_mode = MODE_LINEAR;
        end
    end

    assign dac_level = bit_ff ? CLIP_EXT : NEG_CLIP_EXT;
    assign decision = ~int2_ff[INT_W-1];
    assign cnt_use = (req_mode == mode_ff) ? clip_cnt_ff : 7'h00;

    always_comb begin
        nxt_mode = mode_ff;
        nxt_int1 = int1_ff;
        nxt_int2 = int2_ff;
        nxt_clip_cnt = clip_cnt_ff;
        nxt_bit = bit_ff;
        nxt_strobe = sample_rise;
        if (sample_rise) begin
            nxt_mode = req_mode;
            nxt_clip_cnt = 7'h00;
            nxt_int1 = '0;
            nxt_int2 = '0;
            case (req_mode)
                MODE_LINEAR: begin
                    // Second-order loop; density tracks (x + clip) / (2 * clip)
                    // Doubled feedback into the second integrator keeps the loop stable
                    nxt_int1 = sat_int(EXT_W'(int1_ff) + EXT_W'(i_diff_input) - dac_level);
                    nxt_int2 = sat_int(EXT_W'(int2_ff) + EXT_W'(int1_ff) - dac_level - dac_level);
                    nxt_bit = ~nxt_int2[INT_W-1];
                end
                MODE_CLIP_POS: begin
                    nxt_bit = (cnt_use != MARKER_LAST);
                    nxt_clip_cnt = cnt_use + 7'h01;
                end
                MODE_CLIP_NEG: begin
                    nxt_bit = (cnt_use == MARKER_LAST);
                    nxt_clip_cnt = cnt_use + 7'h01;
                end
                MODE_CM_OVER: begin
                    nxt_bit = 1'b1;
                end
                MODE_NO_SUPPLY: begin
                    nxt_bit = 1'b0;
                end
                default: begin
                    nxt_bit = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_ff <= MODE_NO_SUPPLY;
            int1_ff <= '0;
            int2_ff <= '0;
            clip_cnt_ff <= 7'h00;
            bit_ff <= 1'b0;
            strobe_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            int1_ff <= nxt_int1;
            int2_ff <= nxt_int2;
            clip_cnt_ff <= nxt_clip_cnt;
            bit_ff <= nxt_bit;
            strobe_ff <= nxt_strobe;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_comb begin
        o_mod.bitstream = bit_ff;
        o_mod.carrier_on = bit_ff;
        o_mod.chopper_phase = chop_ff;
        o_mod.bit_strobe = strobe_ff;
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_clip_neg_wrap;
        sample_rise && req_mode == MODE_CLIP_NEG && mode_ff == MODE_CLIP_NEG && clip_cnt_ff == MARKER_LAST;
    endsequence

    sequence s_clip_pos_run;
        sample_rise && req_mode == MODE_CLIP_POS && mode_ff == MODE_CLIP_POS && clip_cnt_ff != MARKER_LAST;
    endsequence

    sequence s_clip_pos_wrap;
        sample_rise && req_mode == MODE_CLIP_POS && mode_ff == MODE_CLIP_POS && clip_cnt_ff == MARKER_LAST;
    endsequence

    sequence s_clip_pos_entry;
        sample_rise && req_mode == MODE_CLIP_POS && mode_ff != MODE_CLIP_POS;
    endsequence

    chk_bit_on_edge: assert property ($changed(bit_ff) |-> $past(sample_rise))
        else $error("bitstream changed without a sample clock edge");
    chk_chop_toggle: assert property ($changed(chop_ff) |-> $past(sample_rise && chop_cnt_ff == CHOP_HALF_LAST))
        else $error("chopper toggled off its divide point");
    chk_dac_latency: assert property (sample_rise && req_mode == MODE_LINEAR |=> bit_ff == decision)
        else $error("output bit does not follow the quantizer decision");
    chk_neg_marker: assert property (s_clip_neg_wrap |=> bit_ff && clip_cnt_ff == 7'h00)
        else $error("negative full-scale marker missing");
    chk_pos_clip: assert property (s_clip_pos_run |=> bit_ff && clip_cnt_ff == $past(clip_cnt_ff) + 7'h01)
        else $error("positive clip stream not all ones");
    chk_cm_high: assert property (sample_rise && pin_filt[PIN_SUPPLY] && pin_filt[PIN_CM] |=> bit_ff)
        else $error("common-mode overvoltage did not hold output high");
    chk_supply_low: assert property (sample_rise && !pin_filt[PIN_SUPPLY] |=> !bit_ff ##1 !strobe_ff)
        else $error("missing supply did not hold output low");
    chk_carrier_gate: assert property ($rose(o_mod.bitstream) |-> o_mod.carrier_on && $past(!o_mod.carrier_on))
        else $error("carrier gate does not follow bit value");

    chk_strobe_edge: assert property (sample_rise |=> strobe_ff ##1 !strobe_ff)
        else $error("bit strobe is not one pulse per sample edge");
    chk_chop_hold: assert property (!sample_rise |=> $stable(chop_ff) && $stable(chop_cnt_ff))
        else $error("chopper moved without a sample clock edge");
    chk_pos_marker: assert property (s_clip_pos_wrap |=> !bit_ff && clip_cnt_ff == 7'h00)
        else $error("positive full-scale marker missing");
    chk_pos_entry: assert property (s_clip_pos_entry |=> bit_ff && clip_cnt_ff == 7'h01)
        else $error("positive clip did not start with a one");
    chk_neg_entry: assert property (sample_rise && req_mode == MODE_CLIP_NEG && mode_ff != MODE_CLIP_NEG |=> !bit_ff && clip_cnt_ff == 7'h01)
        else $error("negative clip did not start with a zero");
    chk_fault_count: assert property (sample_rise && (req_mode == MODE_CM_OVER || req_mode == MODE_NO_SUPPLY) |=> clip_cnt_ff == 7'h00)
        else $error("marker counter runs in a fault mode");
    chk_int_cleared: assert property (sample_rise && req_mode != MODE_LINEAR |=> int1_ff == '0 && int2_ff == '0)
        else $error("integrators not cleared outside the linear mode");

endmodule : isolated_modulator_bitstream_out

// ==== tb/bit_receiver_model.sv ====
// Receiving-side model: supplies the sample clock and tallies the returned bitstream.
// Assumes the block's outputs are registers on the same system clock.
`timescale 1ns/100ps
module bit_receiver_model (
    input wire logic i_sys_clk,
    input wire logic i_clear,
    input wire modulator_out_pkg::mod_out_s i_mod,
    output logic o_sclk,
    output int o_bits,
    output int o_ones,
    output int o_rises,
    output int o_chops,
    output int o_bad,
    output int o_run_max
);
    import modulator_out_pkg::*;
    int phase = 0;
    int run = 0;
    logic sclk_q = 1'b0;
    logic last_bit = 1'b0;
    logic last_chop = 1'b0;

    // ************************************************************
    // Sample clock, 20 MHz: five system cycles high, five low
    // ************************************************************
    always @(negedge i_sys_clk) begin
        phase = (phase + 1) % 10;
        o_sclk <= (phase < 5);
    end

    // ************************************************************
    // Tally of bits, ones, runs and chopper toggles
    // ************************************************************
    always @(posedge i_sys_clk) begin
        if (i_clear) begin
            o_bits = 0;
            o_ones = 0;
            o_rises = 0;
            o_chops = 0;
            o_bad = 0;
            o_run_max = 0;
            run = 0;
        end else begin
            if (o_sclk && !sclk_q) o_rises++;
            if (i_mod.chopper_phase !== last_chop) o_chops++;
            if (i_mod.carrier_on !== i_mod.bitstream) o_bad++;
            if (i_mod.bitstream !== last_bit && i_mod.bit_strobe !== 1'b1) o_bad++;
            if (i_mod.bit_strobe === 1'b1) begin
                o_bits++;
                o_ones += int'(i_mod.bitstream);
                run = (run > 0 && i_mod.bitstream === last_bit) ? run + 1 : 1;
                if (run > o_run_max) o_run_max = run;
            end
        end
        sclk_q = o_sclk;
        last_bit = i_mod.bitstream;
        last_chop = i_mod.chopper_phase;
    end
endmodule : bit_receiver_model

// ==== tb/tb_top.sv ====
// Testbench: drives the differential input and fault pins, judges the tallied bitstream.
// Assumes the receiver model supplies the sample clock at one tenth of the system clock.
`timescale 1ns/100ps
module tb_top;
    import modulator_out_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic signed [15:0] diff = 16'sh0000;
    logic cm_over = 1'b0;
    logic supply_ok = 1'b1;
    logic clear = 1'b1;
    logic sclk;
    pin_in_s pins;
    mod_out_s mod;
    int bits, ones, rises, chops, bad, run_max;
    int err_total = 0;
    int compares = 0;

    always #2.5 i_sys_clk = ~i_sys_clk;
    // Common mode below its minimum is never applied, the stream would be undefined
    assign pins = '{sample_clock_in: sclk, cm_overvoltage: cm_over, high_side_supply_ok: supply_ok};

    isolated_modulator_bitstream_out i_isolated_modulator_bitstream_out (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_pins(pins), .i_diff_input(diff), .o_mod(mod));
    bit_receiver_model i_bit_receiver_model (
        .i_sys_clk(i_sys_clk), .i_clear(clear), .i_mod(mod), .o_sclk(sclk), .o_bits(bits),
        .o_ones(ones), .o_rises(rises), .o_chops(chops), .o_bad(bad), .o_run_max(run_max));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic print_verdict();
        if (err_total == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic check_range(input int got, input int lo, input int hi, input string what);
        compares++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("[FAIL] %0t %s: got %0d, want %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : check_range

    task automatic check_out(input mod_out_s got, input mod_out_s want, input string what);
        compares++;
        if (got !== want) begin
            err_total++;
            $display("[FAIL] %0t %s: got %b, want %b", $time, what, got, want);
        end
    endtask : check_out

    task automatic measure(input int n);
        int guard;
        guard = 0;
        @(negedge i_sys_clk) clear <= 1'b1;
        @(negedge i_sys_clk) clear <= 1'b0;
        while (bits < n && guard < n * 12 + 40) begin
            @(negedge i_sys_clk);
            guard++;
        end
        if (bits < n) begin
            err_total++;
            $display("[FAIL] %0t bitstream stalled", $time);
            print_verdict();
        end else begin
            check_range(bad, 0, 0, "bit change off strobe or carrier mismatch");
            // A rise just before the window may deliver its bit inside it
            check_range(rises - bits, -1, 0, "bits per sample clock");
        end
    endtask : measure

    task automatic apply(input logic signed [15:0] x, input logic cm, input logic sup, input int n);
        @(negedge i_sys_clk);
        diff = x;
        cm_over = cm;
        supply_ok = sup;
        measure(40);
        measure(n);
    endtask : apply

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic test_linear();
        apply(16'sh0000, 1'b0, 1'b1, 256);
        check_range(ones, 124, 132, "zero input density");
        check_range(ones * 256, 31744, 33792, "zero input 16-bit code");
        apply(16'sh61A8, 1'b0, 1'b1, 256);
        check_range(ones, 224, 232, "positive limit density");
        check_range(ones * 256, 57344, 59392, "positive limit 16-bit code");
        apply(16'sh9E58, 1'b0, 1'b1, 256);
        check_range(ones, 24, 32, "negative limit density");
        check_range(ones * 256, 6144, 8192, "negative limit 16-bit code");
    endtask : test_linear

    task automatic test_chopper();
        apply(16'sh0000, 1'b0, 1'b1, 320);
        check_range(chops, 19, 21, "chopper toggles in 320 bits");
    endtask : test_chopper

    task automatic test_clip();
        apply(16'sh7D00, 1'b0, 1'b1, 512);
        check_range(ones, 508, 508, "positive clip markers");
        check_range(run_max, 127, 127, "positive clip marker spacing");
        apply(16'sh8300, 1'b0, 1'b1, 512);
        check_range(ones, 4, 4, "negative clip markers");
        check_range(run_max, 127, 127, "negative clip marker spacing");
    endtask : test_clip

    task automatic test_faults();
        apply(16'sh7D00, 1'b1, 1'b1, 512);
        check_range(ones, 512, 512, "overvoltage holds high");
        apply(16'sh8300, 1'b0, 1'b0, 512);
        check_range(ones, 0, 0, "missing supply holds low");
        check_range(run_max, 512, 512, "missing supply has no marker");
        apply(16'sh7D00, 1'b1, 1'b0, 256);
        check_range(ones, 0, 0, "missing supply beats overvoltage");
    endtask : test_faults

    task automatic test_reset();
        apply(16'sh7D00, 1'b0, 1'b1, 64);
        @(negedge i_sys_clk);
        i_rst_b = 1'b0;
        @(negedge i_sys_clk);
        check_out(mod, 4'h0, "outputs during reset");
        @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        apply(16'sh0000, 1'b0, 1'b1, 256);
        check_range(ones, 124, 132, "density after second reset");
    endtask : test_reset

    initial begin
        repeat (2) @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        test_linear();
        test_chopper();
        test_clip();
        test_faults();
        test_reset();
        print_verdict();
    end
endmodule : tb_top
